// ### src/dfc_fan_pwm.sv
// two independent fan pulse-width controllers with mailbox register access
//
// Summary of operation
// RULE1 - Two separate controllers each own a speed register and an output and never affect each other.
// RULE2 - Each controller offers eleven frequencies, six-bit duty, and forced high or low output.
// RULE3 - A controller runs from the system clock only while main supply is up, or from the 32.768 kHz standby clock.
// RULE4 - Host and microcontroller can read and write every bit of both speed registers.
// RULE5 - With the fast source, select codes give 15.625, 23.438, 0.040, 0.060 kHz, doubled by the double bit.
// RULE6 - With the standby source the double bit is ignored and codes give 0.032, 0.064, 0.128 kHz, 11 reserved.
// RULE7 - Speed bit 0 forces the output continuously high.
// RULE8 - Speed bit 7 is the low select bit, combined with the high select bit in the shared config.
// RULE9 - Config bits 2 and 3 are the double bits of controllers a and b.
// RULE10 - Config bits 0 and 1 are the high select bits of controllers a and b.
// RULE11 - Config bits 4 and 5 pick the standby clock for controllers a and b.
// RULE12 - Duty bits 6:1 give a high time of duty/64, and zero holds the output low.
// RULE13 - Speed registers sit at mailbox 0x92/0x93 and microcontroller 0x7f25/0x7f26.
// RULE14 - Speed registers reset to 0x00 on standby power-on only.
// RULE15 - The shared config register resets to 0x30 on standby power-on.
// RULE16 - A 64-step counter drives the output high while below the duty value.
`timescale 1ns/10ps
`default_nettype none
module dfc_fan_pwm #(
    parameter logic [16:0] DIV00 = 17'(dfc_pkg::DIV00),
    parameter logic [16:0] DIV01 = 17'(dfc_pkg::DIV01),
    parameter logic [16:0] DIV10 = 17'(dfc_pkg::DIV10),
    parameter logic [16:0] DIV11 = 17'(dfc_pkg::DIV11),
    parameter logic [16:0] DDIV10 = 17'(dfc_pkg::DDIV10),
    parameter logic [16:0] DDIV11 = 17'(dfc_pkg::DDIV11)
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow_clk_in,
    input wire logic main_supply_good,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_index,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire logic uc_wr,
    input wire logic uc_rd,
    input wire logic [15:0] uc_addr,
    input wire logic [7:0] uc_wdata,
    output logic [7:0] uc_rdata,
    output logic [1:0] fan_out
);
    localparam int W = dfc_pkg::PRE_W;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] speed_q [2];
    logic [7:0] cfg_q;
    logic [1:0] host_hit;
    logic [1:0] uc_hit;
    logic host_cfg_hit;
    logic uc_cfg_hit;

    assign host_hit[0] = host_index == dfc_pkg::MBX_FAN_A; // RULE13
    assign host_hit[1] = host_index == dfc_pkg::MBX_FAN_B; // RULE13
    assign host_cfg_hit = host_index == dfc_pkg::MBX_FAN_CFG;
    assign uc_hit[0] = uc_addr == dfc_pkg::UC_FAN_A; // RULE13
    assign uc_hit[1] = uc_addr == dfc_pkg::UC_FAN_B; // RULE13
    assign uc_cfg_hit = uc_addr == dfc_pkg::UC_FAN_CFG;

    // microcontroller write lands last, so it wins a same-cycle clash
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            speed_q[0] <= dfc_pkg::SPEED_RST; // RULE14
            speed_q[1] <= dfc_pkg::SPEED_RST; // RULE14
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (host_wr && host_hit[i]) begin
                    speed_q[i] <= host_wdata; // RULE4
                end
                if (uc_wr && uc_hit[i]) begin
                    speed_q[i] <= uc_wdata; // RULE4
                end
            end
        end
    end

    // reserved bits 7:6 cannot be written
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_q <= dfc_pkg::CFG_RST; // RULE15
        end else if (uc_wr && uc_cfg_hit) begin
            cfg_q <= uc_wdata & dfc_pkg::CFG_WR_MASK;
        end else if (host_wr && host_cfg_hit) begin
            cfg_q <= host_wdata & dfc_pkg::CFG_WR_MASK;
        end
    end

    // unmapped index reads as zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            host_rdata <= host_hit[0] ? speed_q[0] : host_hit[1] ? speed_q[1] : host_cfg_hit ? cfg_q : 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            uc_rdata <= 8'h00;
        end else if (uc_rd) begin
            uc_rdata <= uc_hit[0] ? speed_q[0] : uc_hit[1] ? speed_q[1] : uc_cfg_hit ? cfg_q : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers and standby tick
    // ------------------------------------------------------------
    logic slow_s1_q, slow_s2_q, slow_s3_q;
    logic main_s1_q, main_s2_q;
    logic slow_tick;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            slow_s1_q <= 1'b0;
            slow_s2_q <= 1'b0;
            slow_s3_q <= 1'b0;
        end else begin
            slow_s1_q <= slow_clk_in;
            slow_s2_q <= slow_s1_q;
            slow_s3_q <= slow_s2_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            main_s1_q <= 1'b0;
            main_s2_q <= 1'b0;
        end else begin
            main_s1_q <= main_supply_good;
            main_s2_q <= main_s1_q;
        end
    end

    assign slow_tick = slow_s2_q & ~slow_s3_q;

    // ------------------------------------------------------------
    // per-controller rate divider and 64-step generator
    // ------------------------------------------------------------
    logic [W-1:0] pre_q [2];
    logic [5:0] phase_q [2];
    logic [W-1:0] reload [2];
    logic [1:0] step;
    logic [1:0] use_slow;

    for (genvar i = 0; i < 2; i++) begin : g_chan // RULE1
        logic sel1;
        logic sel0;
        logic dbl;
        logic en;
        logic [5:0] duty;

        assign sel0 = speed_q[i][dfc_pkg::SPD_SEL0_BIT]; // RULE8
        assign sel1 = cfg_q[dfc_pkg::CFG_SEL1_BIT + i]; // RULE10
        assign dbl = cfg_q[dfc_pkg::CFG_DBL_BIT + i]; // RULE9
        assign use_slow[i] = cfg_q[dfc_pkg::CFG_SLOW_BIT + i]; // RULE11
        assign duty = speed_q[i][dfc_pkg::SPD_DUTY_LSB +: 6];

        // fast source stalls without main supply; reload 0 never steps
        always_comb begin
            reload[i] = '0;
            if (use_slow[i]) begin
                unique case ({sel1, sel0}) // RULE6
                    2'b00: reload[i] = W'(dfc_pkg::SDIV00);
                    2'b01: reload[i] = W'(dfc_pkg::SDIV01);
                    2'b10: reload[i] = W'(dfc_pkg::SDIV10);
                    2'b11: reload[i] = '0;
                endcase
            end else begin
                unique case ({dbl, sel1, sel0}) // RULE5
                    3'b000: reload[i] = DIV00;
                    3'b001: reload[i] = DIV01;
                    3'b010: reload[i] = DIV10;
                    3'b011: reload[i] = DIV11;
                    3'b100: reload[i] = W'(dfc_pkg::DDIV00);
                    3'b101: reload[i] = W'(dfc_pkg::DDIV01);
                    3'b110: reload[i] = DDIV10;
                    3'b111: reload[i] = DDIV11;
                endcase
            end
        end

        assign en = use_slow[i] ? slow_tick : main_s2_q; // RULE3
        // >= so a shorter period chosen mid-count wraps at once
        assign step[i] = en && (reload[i] != '0) && (pre_q[i] >= reload[i] - W'(1));

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                pre_q[i] <= '0;
            end else if (step[i]) begin
                pre_q[i] <= '0;
            end else if (en) begin
                pre_q[i] <= pre_q[i] + W'(1);
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                phase_q[i] <= 6'h00;
            end else if (step[i]) begin
                phase_q[i] <= phase_q[i] + 6'h01; // RULE16
            end
        end

        // force high overrides duty; duty 0 never beats the count
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                fan_out[i] <= 1'b0;
            end else begin
                fan_out[i] <= speed_q[i][dfc_pkg::SPD_FORCE_BIT] | (phase_q[i] < duty); // RULE2 RULE7 RULE12 RULE16
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // clocks since the last step of a, saturating; lets the period check follow the divider parameter
    logic [W-1:0] gap_a_q;
    always_ff @(posedge clk_sys) begin
        if (rst || step[0]) begin
            gap_a_q <= '0;
        end else if (gap_a_q != '1) begin
            gap_a_q <= gap_a_q + W'(1);
        end
    end

    force_high_a: assert property (speed_q[0][0] |=> fan_out[0]) // RULE7
        else $error("forced output a not high");
    duty_zero_a: assert property (speed_q[1] == 8'h00 |=> !fan_out[1]) // RULE12
        else $error("zero duty output b not low");
    duty_compare_a: assert property (!speed_q[0][0] && phase_q[0] >= speed_q[0][6:1] |=> !fan_out[0]) // RULE12
        else $error("output a high past duty");
    host_write_a: assert property (host_wr && host_index == dfc_pkg::MBX_FAN_A && !uc_wr
        |=> speed_q[0] == $past(host_wdata)) // RULE4
        else $error("host write to speed a lost");
    uc_write_a: assert property (uc_wr && uc_addr == dfc_pkg::UC_FAN_B |=> speed_q[1] == $past(uc_wdata)) // RULE13
        else $error("microcontroller write to speed b lost");
    chan_isolation_a: assert property (host_wr && host_index == dfc_pkg::MBX_FAN_A && !uc_wr
        |=> $stable(speed_q[1])) // RULE1
        else $error("write to a disturbed b");
    main_down_a: assert property (!use_slow[0] && !main_s2_q |-> !step[0]) // RULE3
        else $error("fast source stepped without main supply");
    reserved_code_a: assert property (use_slow[1] && speed_q[1][7] && cfg_q[1] |-> !step[1]) // RULE6
        else $error("reserved standby code stepped");
    phase_advance_a: assert property (step[0] |=> phase_q[0] == $past(phase_q[0]) + 6'h01) // RULE16
        else $error("phase a did not advance");
    fast_period_a: assert property (step[0] && !use_slow[0] && cfg_q[2] == 1'b0 && cfg_q[0] == 1'b0
        && !speed_q[0][7] && main_s2_q |-> gap_a_q >= DIV00 - 17'h1) // RULE5
        else $error("fast period a too short");
    reset_values_a: assert property ($fell(rst) |-> speed_q[0] == dfc_pkg::SPEED_RST // RULE14 RULE15
        && speed_q[1] == dfc_pkg::SPEED_RST && cfg_q == dfc_pkg::CFG_RST)
        else $error("reset values wrong");
endmodule
`default_nettype wire

// ### src/dfc_pkg.sv
// constants shared by the dual fan pulse-width controller
package dfc_pkg;
    // ------------------------------------------------------------
    // mailbox indices (host) and local addresses (microcontroller)
    // ------------------------------------------------------------
    localparam logic [7:0] MBX_FAN_A = 8'h92;
    localparam logic [7:0] MBX_FAN_B = 8'h93;
    localparam logic [7:0] MBX_FAN_CFG = 8'h9d;
    localparam logic [15:0] UC_FAN_A = 16'h7f25;
    localparam logic [15:0] UC_FAN_B = 16'h7f26;
    localparam logic [15:0] UC_FAN_CFG = 16'h7f28;
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] SPEED_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h30;
    localparam logic [7:0] CFG_WR_MASK = 8'h3f;
    localparam int SPD_FORCE_BIT = 0;
    localparam int SPD_DUTY_LSB = 1;
    localparam int SPD_SEL0_BIT = 7;
    localparam int CFG_SEL1_BIT = 0;
    localparam int CFG_DBL_BIT = 2;
    localparam int CFG_SLOW_BIT = 4;
    // ------------------------------------------------------------
    // timing: output frequencies in Hz, 64 steps per period
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int STEPS = 64;
    localparam int F_SEL00_HZ = 15625;
    localparam int F_SEL01_HZ = 23438;
    localparam int F_SEL10_HZ = 40;
    localparam int F_SEL11_HZ = 60;
    localparam int F_DBL00_HZ = 31250;
    localparam int F_DBL01_HZ = 46876;
    localparam int F_DBL10_HZ = 80;
    localparam int F_DBL11_HZ = 120;
    localparam int SLOW_HZ = 32768;
    localparam int F_SLOW00_HZ = 32;
    localparam int F_SLOW01_HZ = 64;
    localparam int F_SLOW10_HZ = 128;
    // system clocks per step, rounded to nearest
    localparam int DIV00 = (CLK_HZ + STEPS / 2 * F_SEL00_HZ) / (STEPS * F_SEL00_HZ);
    localparam int DIV01 = (CLK_HZ + STEPS / 2 * F_SEL01_HZ) / (STEPS * F_SEL01_HZ);
    localparam int DIV10 = (CLK_HZ + STEPS / 2 * F_SEL10_HZ) / (STEPS * F_SEL10_HZ);
    localparam int DIV11 = (CLK_HZ + STEPS / 2 * F_SEL11_HZ) / (STEPS * F_SEL11_HZ);
    localparam int DDIV00 = (CLK_HZ + STEPS / 2 * F_DBL00_HZ) / (STEPS * F_DBL00_HZ);
    localparam int DDIV01 = (CLK_HZ + STEPS / 2 * F_DBL01_HZ) / (STEPS * F_DBL01_HZ);
    localparam int DDIV10 = (CLK_HZ + STEPS / 2 * F_DBL10_HZ) / (STEPS * F_DBL10_HZ);
    localparam int DDIV11 = (CLK_HZ + STEPS / 2 * F_DBL11_HZ) / (STEPS * F_DBL11_HZ);
    // standby clock ticks per step
    localparam int SDIV00 = SLOW_HZ / (STEPS * F_SLOW00_HZ);
    localparam int SDIV01 = SLOW_HZ / (STEPS * F_SLOW01_HZ);
    localparam int SDIV10 = SLOW_HZ / (STEPS * F_SLOW10_HZ);
    localparam int PRE_W = 17;
endpackage

// ### dv/dfc_fan_meter.sv
// fan load model: measures pulse period and high time on one fan output
`timescale 1ns/10ps
`default_nettype none
module dfc_fan_meter (
    input wire logic clk_sys,
    input wire logic pwm_in,
    output var logic [19:0] period_q = 20'h0,
    output var logic [19:0] high_q = 20'h0,
    output var logic [7:0] rises_q = 8'h0
);
    logic prev_q = 1'b0;
    logic [19:0] cnt_q = 20'h0;
    logic [19:0] hcnt_q = 20'h0;
    // each rising edge closes one full period of the waveform
    always @(posedge clk_sys) begin
        prev_q <= pwm_in;
        if (pwm_in && !prev_q) begin
            period_q <= cnt_q;
            high_q <= hcnt_q;
            rises_q <= rises_q + 8'h1;
            cnt_q <= 20'h1;
            hcnt_q <= 20'h1;
        end else begin
            cnt_q <= cnt_q + 20'h1;
            hcnt_q <= hcnt_q + {19'h0, pwm_in};
        end
    end
endmodule
`default_nettype wire

// ### dv/test_dual_fan_pwm_controller.sv
// self-checking bench for the dual fan pulse-width controller
`timescale 1ns/10ps
`default_nettype none
module test_dual_fan_pwm_controller;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic slow_clk_in = 1'b0;
    logic main_supply_good = 1'b1;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic uc_wr = 1'b0;
    logic uc_rd = 1'b0;
    logic [7:0] host_index = 8'h00;
    logic [7:0] host_wdata = 8'h00;
    logic [15:0] uc_addr = 16'h0000;
    logic [7:0] uc_wdata = 8'h00;
    logic [7:0] host_rdata;
    logic [7:0] uc_rdata;
    logic [1:0] fan_out;
    logic [19:0] per_a;
    logic [19:0] per_b;
    logic [19:0] hi_a;
    logic [19:0] hi_b;
    logic [7:0] rise_a;
    logic [7:0] rise_b;
    logic [7:0] rd;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int j;
    // system clocks per step, indexed by {sel1, sel0, double}
    int divs[8] = '{4, dfc_pkg::DDIV00, dfc_pkg::DIV01, dfc_pkg::DDIV01, 8, 3, 10, 5};
    always #2.5 clk_sys = ~clk_sys;
    // standby clock sped up to 2 system clocks a tick to keep the run short
    always #5 slow_clk_in = ~slow_clk_in;
    dfc_fan_pwm #(.DIV00(17'h4), .DIV10(17'h8), .DIV11(17'ha), .DDIV10(17'h3), .DDIV11(17'h5)) DUT (
        .clk_sys(clk_sys), .rst(rst), .slow_clk_in(slow_clk_in), .main_supply_good(main_supply_good),
        .host_wr(host_wr), .host_rd(host_rd), .host_index(host_index), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .uc_wr(uc_wr), .uc_rd(uc_rd), .uc_addr(uc_addr), .uc_wdata(uc_wdata),
        .uc_rdata(uc_rdata), .fan_out(fan_out));
    dfc_fan_meter fan_a (.clk_sys(clk_sys), .pwm_in(fan_out[0]), .period_q(per_a), .high_q(hi_a), .rises_q(rise_a));
    dfc_fan_meter fan_b (.clk_sys(clk_sys), .pwm_in(fan_out[1]), .period_q(per_b), .high_q(hi_b), .rises_q(rise_b));
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic acc(input bit uc, input bit wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        if (uc) begin
            uc_wr = wr;
            uc_rd = !wr;
            uc_addr = a;
            uc_wdata = d;
        end else begin
            host_wr = wr;
            host_rd = !wr;
            host_index = a[7:0];
            host_wdata = d;
        end
        @(negedge clk_sys);
        {host_wr, host_rd, uc_wr, uc_rd} = 4'h0;
        @(negedge clk_sys);
        rd = uc ? uc_rdata : host_rdata;
    endtask
    task automatic rdchk(input bit uc, input logic [15:0] a, input logic [7:0] exp);
        acc(uc, 1'b0, a, 8'h00);
        check({12'h0, rd}, {12'h0, exp});
    endtask
    task automatic setup(input logic [7:0] sa, input logic [7:0] sb, input logic [7:0] cfg);
        acc(1'b0, 1'b1, 16'h0092, sa);
        acc(1'b1, 1'b1, 16'h7f26, sb);
        acc(1'b0, 1'b1, 16'h009d, cfg);
    endtask
    // two rising edges after a change: the second closes a period run wholly on the new settings
    task automatic settle(input bit need_b);
        logic [7:0] ra;
        logic [7:0] rb;
        ra = rise_a;
        rb = rise_b;
        for (int i = 0; i < 30000 && !(rise_a - ra >= 8'h2 && (!need_b || rise_b - rb >= 8'h2)); i++) begin
            @(negedge clk_sys);
        end
    endtask
    task automatic stall(input int n);
        logic [7:0] ra;
        // let an edge already in flight from the last write reach the meter first
        repeat (4) @(negedge clk_sys);
        ra = rise_a;
        repeat (n) @(negedge clk_sys);
        check({12'h0, rise_a}, {12'h0, ra});
    endtask
    task automatic hold(input int b, input logic v, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (fan_out[b] !== v) bad++;
        end
        check(20'(bad), 20'h0);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 95000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check({18'h0, fan_out}, 20'h0);
        rdchk(1'b0, 16'h0092, 8'h00);
        rdchk(1'b1, 16'h7f26, 8'h00);
        rdchk(1'b0, 16'h009d, 8'h30);
        acc(1'b0, 1'b1, 16'h0092, 8'ha5);
        rdchk(1'b1, 16'h7f25, 8'ha5);
        acc(1'b1, 1'b1, 16'h7f26, 8'h5a);
        rdchk(1'b0, 16'h0093, 8'h5a);
        acc(1'b0, 1'b1, 16'h009d, 8'hff);
        rdchk(1'b1, 16'h7f28, 8'h3f);
        rdchk(1'b0, 16'h0094, 8'h00);
        setup(8'h21, 8'h00, 8'h3f);
        hold(0, 1'b1, 600);
        hold(1, 1'b0, 600);
        for (int i = 0; i < 8; i++) begin
            j = i ^ 2;
            setup({i[1], 6'h10, 1'b0}, {j[1], 6'h28, 1'b0}, {4'h0, j[0], i[0], j[2], i[2]});
            settle(1'b1);
            check(per_a, 20'(64 * divs[i]));
            check(hi_a, 20'(16 * divs[i]));
            check(per_b, 20'(64 * divs[j]));
            check(hi_b, 20'(40 * divs[j]));
        end
        for (int k = 0; k < 3; k++) begin
            j = 2 - k;
            setup({k[0], 6'h08, 1'b0}, {j[0], 6'h30, 1'b0}, {4'h3, 2'h3, j[1], k[1]});
            settle(1'b1);
            check(per_a, 20'(128 * (16 >> k)));
            check(hi_a, 20'(16 * (16 >> k)));
            check(per_b, 20'(128 * (16 >> j)));
            check(hi_b, 20'(96 * (16 >> j)));
        end
        setup(8'h7e, 8'h00, 8'h00);
        settle(1'b0);
        check(per_a, 20'd256);
        check(hi_a, 20'd252);
        hold(1, 1'b0, 600);
        main_supply_good = 1'b0;
        repeat (8) @(negedge clk_sys);
        stall(3000);
        main_supply_good = 1'b1;
        setup(8'ha0, 8'ha0, 8'h33);
        stall(3000);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        rdchk(1'b1, 16'h7f25, 8'h00);
        rdchk(1'b0, 16'h009d, 8'h30);
        final_report();
    end
endmodule
`default_nettype wire
